// ### core/els_pkg.sv
// Package: constants for the Ethernet link supervision block
package els_pkg;
  // Protocol-selection slot codes
  localparam logic [15:0] ELS_CODE_REGTCP = 16'h01f6;   // Register access over TCP
  localparam logic [15:0] ELS_CODE_5002 = 16'h138a;
  localparam logic [15:0] ELS_CODE_5007 = 16'h138f;
  localparam logic [15:0] ELS_CODE_5012 = 16'h1394;
  localparam logic [15:0] ELS_CODE_5013 = 16'h1395;
  localparam logic [15:0] ELS_CODE_5011 = 16'h1393;
  localparam logic [15:0] ELS_CODE_5010 = 16'h1392;
  localparam logic [15:0] ELS_CODE_5001 = 16'h1389;
  localparam logic [15:0] ELS_CODE_5006 = 16'h138e;
  localparam logic [15:0] ELS_CODE_5008 = 16'h1390;
  localparam logic [15:0] ELS_CODE_5000 = 16'h1388;
  localparam logic [15:0] ELS_CODE_DIAGOFF = 16'h8892;  // 34962, blocks SNMP
  localparam logic [15:0] ELS_CODE_CYCLIC = 16'hb0b6;   // 45238, cyclic time-sensitive
  localparam logic [15:0] ELS_CODE_44818 = 16'haf12;    // 44818
  localparam logic [15:0] ELS_CODE_UNSEL = 16'h270f;    // 9999
  // Client limits; 0 means unlimited
  localparam logic [1:0] ELS_CLI_UNLIM = 2'h0;
  localparam logic [1:0] ELS_CLI_TWO = 2'h2;
  localparam logic [1:0] ELS_CLI_THREE = 2'h3;
  // Loss action encodings
  localparam logic [13:0] ELS_ACT_OFF = 14'h0000;
  localparam logic [13:0] ELS_ACT_WARN = 14'h0001;
  localparam logic [13:0] ELS_ACT_ALARM = 14'h0002;
  localparam logic [13:0] ELS_ACT_PROT = 14'h0003;
  localparam logic [13:0] ELS_ACT_BOTH = 14'h22b8;      // 8888
  localparam logic [13:0] ELS_ACT_EITHER = 14'h270f;    // 9999
  // Network diagnosis encodings
  localparam logic [13:0] ELS_DIAG_OFF = 14'h0000;
  localparam logic [13:0] ELS_DIAG_SNMP = 14'h0001;
  localparam logic [13:0] ELS_DIAG_DUP = 14'h0002;
  localparam logic [13:0] ELS_DIAG_ALL = 14'h270f;
  // Keepalive
  localparam int ELS_CLK_HZ = 100000000;
  localparam int ELS_SEC_CYCLES = ELS_CLK_HZ;           // One second at 100 MHz
  localparam logic [12:0] ELS_KA_DEFAULT = 13'h003c;    // 60 s
  localparam logic [12:0] ELS_KA_MIN = 13'h0001;
  localparam logic [12:0] ELS_KA_MAX = 13'h1c20;        // 7200 s
  localparam logic [3:0] ELS_KA_PROBES = 4'h7;          // Close after this many probes
  localparam logic [7:0] ELS_MASK_RST_HI = 8'hff;
  localparam logic [7:0] ELS_MASK_RST_LO = 8'h00;
endpackage

// ### core/els_supervisor.sv
// Module: Ethernet link supervision, slot selection, keepalive and diagnosis
`timescale 1ns/100ps
module els_supervisor import els_pkg::*; #(
  parameter int SEC_CYCLES = ELS_SEC_CYCLES  // Cycles per second, shorten in simulation
) (
  input wire logic clk,                      // 100 MHz clock
  input wire logic rst_n,                    // Async reset, active low
  input wire logic [15:0] proto_select_slot1, // Slot 1 code
  input wire logic [15:0] proto_select_slot2, // Slot 2 code
  input wire logic [15:0] proto_select_slot3, // Slot 3 code
  input wire logic [15:0] proto_select_slot4, // Slot 4 code
  input wire logic [13:0] first_port_loss_action, // First-port action
  input wire logic [13:0] second_port_loss_action, // Second-port action or combine mode
  input wire logic [1:0] comm_error_stop_mode, // Stop mode on comm error
  input wire logic drive_running,            // Drive is operating
  input wire logic cyclic_active,            // Cyclic data exchange in progress
  input wire logic first_port_link_up,       // First port link status
  input wire logic second_port_link_up,      // Second port link status
  input wire logic [12:0] keepalive_interval, // Seconds
  input wire logic tcp_open,                 // TCP connection established
  input wire logic peer_response,            // Peer traffic seen
  input wire logic [13:0] net_diag_select,   // Diagnosis selection
  input wire logic dup_ip_found,             // Duplicate address probe result
  input wire logic [7:0] netmask_octet1_in,  // Written mask octet 1
  input wire logic [7:0] netmask_octet2_in,  // Written mask octet 2
  input wire logic [7:0] netmask_octet3_in,  // Written mask octet 3
  input wire logic [7:0] netmask_octet4_in,  // Written mask octet 4
  output logic [3:0] slot_valid,             // Slot honoured after dedup
  output logic [7:0] slot_clients,           // Two bits per slot, 0 = unlimited
  output logic link_loss_warning,            // Warning indication
  output logic minor_alarm_output,           // Alarm output
  output logic link_loss_fault,              // Protective stop request
  output logic [1:0] fault_stop_mode,        // Stop mode with the fault
  output logic keepalive_probe,              // One-cycle probe pulse
  output logic tcp_force_close,              // One-cycle close pulse
  output logic snmp_enable,                  // SNMP diagnosis enabled
  output logic dup_check_req,                // One-cycle duplicate check on link-up
  output logic duplicate_address_fault,      // Sticky duplicate fault
  output logic [31:0] netmask                // Active mask
);

  // Client limit per code; dedup uses els_group, not this class
  function automatic logic [1:0] els_clients(input logic [15:0] c);
    if (c == ELS_CODE_REGTCP) begin
      els_clients = ELS_CLI_THREE;
    end else if (c == ELS_CODE_5002 || c == ELS_CODE_5007 || c == ELS_CODE_5012 ||
                 c == ELS_CODE_5013 || c == ELS_CODE_44818) begin
      els_clients = ELS_CLI_TWO;
    end else begin
      els_clients = ELS_CLI_UNLIM;
    end
  endfunction

  // Application and transport group; equal nonzero groups are duplicates
  function automatic logic [3:0] els_group(input logic [15:0] c);
    if (c == ELS_CODE_5000 || c == ELS_CODE_5001 || c == ELS_CODE_5006 ||
        c == ELS_CODE_5008) begin
      els_group = 4'h1;
    end else if (c == ELS_CODE_5002 || c == ELS_CODE_5007) begin
      els_group = 4'h2;
    end else if (c == ELS_CODE_5010 || c == ELS_CODE_5011) begin
      els_group = 4'h3;
    end else if (c == ELS_CODE_5012 || c == ELS_CODE_5013) begin
      els_group = 4'h4;
    end else begin
      els_group = 4'h0;
    end
  endfunction

  // Same application and transport
  function automatic logic els_dup(input logic [15:0] a, input logic [15:0] b);
    els_dup = (els_group(a) != 4'h0) ? (els_group(a) == els_group(b)) : (a == b);
  endfunction

  // Slot dedup: a lower-numbered slot wins over later ones
  wire s1_ok = proto_select_slot1 != ELS_CODE_UNSEL;
  wire s2_ok = proto_select_slot2 != ELS_CODE_UNSEL && !els_dup(proto_select_slot2,
               proto_select_slot1);
  wire s3_ok = proto_select_slot3 != ELS_CODE_UNSEL &&
               !els_dup(proto_select_slot3, proto_select_slot1) &&
               !els_dup(proto_select_slot3, proto_select_slot2);
  wire s4_ok = proto_select_slot4 != ELS_CODE_UNSEL &&
               !els_dup(proto_select_slot4, proto_select_slot1) &&
               !els_dup(proto_select_slot4, proto_select_slot2) &&
               !els_dup(proto_select_slot4, proto_select_slot3);
  wire [3:0] valid_next = {s4_ok, s3_ok, s2_ok, s1_ok};
  wire [7:0] clients_next = {els_clients(proto_select_slot4),
                             els_clients(proto_select_slot3),
                             els_clients(proto_select_slot2),
                             els_clients(proto_select_slot1)};

  // Loss evaluation, combinational so action lands next edge
  wire loss1 = !first_port_link_up;
  wire loss2 = !second_port_link_up;
  wire combine_both = second_port_loss_action == ELS_ACT_BOTH;
  wire combine_either = second_port_loss_action == ELS_ACT_EITHER;
  wire combined = combine_both || combine_either;
  wire comb_loss = combine_both ? (loss1 && loss2) : (loss1 || loss2);
  wire p1_hit = combined ? comb_loss : loss1;
  wire p2_hit = !combined && loss2;
  wire warn1 = p1_hit && first_port_loss_action != ELS_ACT_OFF && first_port_loss_action <= ELS_ACT_PROT;
  wire warn2 = p2_hit && second_port_loss_action != ELS_ACT_OFF && second_port_loss_action <= ELS_ACT_PROT;
  wire alarm1 = p1_hit && (first_port_loss_action == ELS_ACT_ALARM ||
                first_port_loss_action == ELS_ACT_PROT);
  wire alarm2 = p2_hit && (second_port_loss_action == ELS_ACT_ALARM ||
                second_port_loss_action == ELS_ACT_PROT);
  wire prot_cfg = (p1_hit && first_port_loss_action == ELS_ACT_PROT) ||
                  (p2_hit && second_port_loss_action == ELS_ACT_PROT);
  wire cyc_sel = proto_select_slot1 == ELS_CODE_CYCLIC || proto_select_slot2 == ELS_CODE_CYCLIC ||
                 proto_select_slot3 == ELS_CODE_CYCLIC || proto_select_slot4 == ELS_CODE_CYCLIC;
  wire cyc_fault = cyc_sel && cyclic_active && (loss1 || loss2);
  wire fault_next = (prot_cfg && drive_running) || cyc_fault;

  // Slot and loss outputs registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_valid <= 4'h0;
      slot_clients <= 8'h00;
      link_loss_warning <= 1'b0;
      minor_alarm_output <= 1'b0;
      link_loss_fault <= 1'b0;
      fault_stop_mode <= 2'h0;
    end else begin
      slot_valid <= valid_next;
      slot_clients <= clients_next;
      link_loss_warning <= warn1 || warn2;
      minor_alarm_output <= alarm1 || alarm2;
      link_loss_fault <= fault_next;
      fault_stop_mode <= comm_error_stop_mode;
    end
  end

  // Keepalive: seconds prescaler, interval counter, probe counter
  logic [31:0] sec_reg;
  logic [12:0] ka_sec_reg;
  logic [3:0] probes_reg;
  wire [12:0] ka_lim = (keepalive_interval < ELS_KA_MIN) ? ELS_KA_MIN :
                       (keepalive_interval > ELS_KA_MAX) ? ELS_KA_MAX : keepalive_interval;
  wire sec_tick = sec_reg == 32'(SEC_CYCLES - 1);
  wire ka_expire = tcp_open && sec_tick && (ka_sec_reg + 13'h0001 >= ka_lim);
  wire send_probe = ka_expire && probes_reg < ELS_KA_PROBES;
  wire do_close = ka_expire && probes_reg == ELS_KA_PROBES;

  // Silence timer restarts on any peer answer or closed link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_reg <= 32'h0000_0000;
      ka_sec_reg <= 13'h0000;
      probes_reg <= 4'h0;
      keepalive_probe <= 1'b0;
      tcp_force_close <= 1'b0;
    end else begin
      if (!tcp_open || peer_response) begin
        sec_reg <= 32'h0000_0000;
        ka_sec_reg <= 13'h0000;
        probes_reg <= 4'h0;
      end else begin
        sec_reg <= sec_tick ? 32'h0000_0000 : sec_reg + 32'h0000_0001;
        ka_sec_reg <= ka_expire ? 13'h0000 : (sec_tick ? ka_sec_reg + 13'h0001 : ka_sec_reg);
        probes_reg <= do_close ? 4'h0 : (send_probe ? probes_reg + 4'h1 : probes_reg);
      end
      keepalive_probe <= send_probe && !peer_response;
      tcp_force_close <= do_close && !peer_response;
    end
  end

  // Diagnosis selection
  wire diag_block = proto_select_slot1 == ELS_CODE_DIAGOFF ||
                    proto_select_slot2 == ELS_CODE_DIAGOFF ||
                    proto_select_slot3 == ELS_CODE_DIAGOFF ||
                    proto_select_slot4 == ELS_CODE_DIAGOFF;
  wire snmp_next = (net_diag_select == ELS_DIAG_SNMP || net_diag_select == ELS_DIAG_ALL) &&
                   !diag_block;
  wire dup_en = net_diag_select == ELS_DIAG_DUP || net_diag_select == ELS_DIAG_ALL;
  logic [1:0] up_reg;
  wire link_up_edge = (first_port_link_up && !up_reg[0]) || (second_port_link_up && !up_reg[1]);

  // Link-up check request; fault sticks until reset
  // A link already up at reset release counts as a link-up, so the check runs at start-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_reg <= 2'h0;
      snmp_enable <= 1'b0;
      dup_check_req <= 1'b0;
      duplicate_address_fault <= 1'b0;
    end else begin
      up_reg <= {second_port_link_up, first_port_link_up};
      snmp_enable <= snmp_next;
      dup_check_req <= dup_en && link_up_edge;
      duplicate_address_fault <= duplicate_address_fault || (dup_en && dup_ip_found);
    end
  end

  // Mask captured once after reset release; later writes wait for reset
  logic mask_taken_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_taken_reg <= 1'b0;
      netmask <= {ELS_MASK_RST_HI, ELS_MASK_RST_HI, ELS_MASK_RST_HI, ELS_MASK_RST_LO};
    end else if (!mask_taken_reg) begin
      mask_taken_reg <= 1'b1;
      netmask <= {netmask_octet1_in, netmask_octet2_in,
                  netmask_octet3_in, netmask_octet4_in};
    end
  end

  // Warning follows loss within one cycle; the reset-release edge still resets outputs
  a_warn_follows: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && loss1 && first_port_loss_action == ELS_ACT_WARN && combine_either) |=>
    link_loss_warning)
    else $error("warning missed on loss");
  // Both-mode needs both ports down
  a_both_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (combine_both && first_port_link_up && first_port_loss_action == ELS_ACT_WARN) |=>
    !link_loss_warning)
    else $error("both-mode warned on one port");
  // No protective stop while stopped unless cyclic
  a_stop_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!drive_running && !cyc_fault) |=> !link_loss_fault)
    else $error("fault while stopped");
  // Cyclic loss forces fault, once out of reset
  a_cyc_fault: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && cyc_fault) |=> link_loss_fault)
    else $error("cyclic loss without fault");
  // Alarm only for action 2 or 3
  a_alarm_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (first_port_loss_action <= ELS_ACT_WARN && !combined && second_port_loss_action <= ELS_ACT_WARN)
    |=> !minor_alarm_output)
    else $error("alarm with low action");
  // SNMP blocked by slot code
  a_snmp_block: assert property (@(posedge clk) disable iff (!rst_n)
    diag_block |=> !snmp_enable)
    else $error("snmp on with blocking code");
  // Close pulse only after seven probes
  a_close_after: assert property (@(posedge clk) disable iff (!rst_n)
    tcp_force_close |-> $past(probes_reg) == ELS_KA_PROBES)
    else $error("close before seventh probe");
  // Stop mode passes through, not across the reset-release edge
  a_stop_mode: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> fault_stop_mode == $past(comm_error_stop_mode))
    else $error("stop mode not carried");
  // Mask stable after capture
  a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n)
    mask_taken_reg |=> $stable(netmask))
    else $error("mask changed without reset");
  // Slot 2 duplicate of slot 1 dropped
  a_dedup: assert property (@(posedge clk) disable iff (!rst_n)
    (s1_ok && els_dup(proto_select_slot2, proto_select_slot1)) |=> !slot_valid[1])
    else $error("duplicate slot kept");
  // No probe or close on a closed connection
  a_probe_open: assert property (@(posedge clk) disable iff (!rst_n)
    !tcp_open |=> !keepalive_probe)
    else $error("probe on closed connection");
  a_close_open: assert property (@(posedge clk) disable iff (!rst_n)
    !tcp_open |=> !tcp_force_close)
    else $error("close on closed connection");
  // Any peer answer restarts supervision, so nothing goes out next cycle
  a_peer_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    peer_response |=> (!keepalive_probe && !tcp_force_close))
    else $error("probe despite peer answer");
  // Diagnosis off keeps SNMP off
  a_snmp_off: assert property (@(posedge clk) disable iff (!rst_n)
    (net_diag_select == ELS_DIAG_OFF) |=> !snmp_enable)
    else $error("snmp on with diagnosis off");
  // Diagnosis off asks for no duplicate check
  a_dup_req_off: assert property (@(posedge clk) disable iff (!rst_n)
    (net_diag_select == ELS_DIAG_OFF) |=> !dup_check_req)
    else $error("duplicate check with diagnosis off");
  // Duplicate fault holds until reset
  a_dup_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    duplicate_address_fault |=> duplicate_address_fault)
    else $error("duplicate fault dropped");
  // Detection off on both ports gives no warning
  a_loss_off: assert property (@(posedge clk) disable iff (!rst_n)
    (first_port_loss_action == ELS_ACT_OFF && second_port_loss_action == ELS_ACT_OFF) |=>
    !link_loss_warning)
    else $error("warning with detection off");
  // Both links up: no loss indication of any kind
  a_links_up: assert property (@(posedge clk) disable iff (!rst_n)
    (first_port_link_up && second_port_link_up) |=>
    (!link_loss_warning && !minor_alarm_output && !link_loss_fault))
    else $error("loss shown with both links up");

endmodule

// ### verification/els_peer_model.sv
// Remote TCP peer model for the link supervision bench
`timescale 1ns/100ps
module els_peer_model (
  input wire logic clk, // Bench clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [1:0] mode, // 1 prompt, 2 slow, else silent
  input wire logic keepalive_probe, // Probe from the device
  input wire logic tcp_force_close, // Close from the device
  output logic tcp_open, // Peer holds the connection
  output logic peer_response // Answer pulse
);
  logic [2:0] wait_reg;
  // Slow answers come four cycles late, so a short interval may run out first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcp_open <= 1'b0;
      peer_response <= 1'b0;
      wait_reg <= 3'h0;
    end else begin
      tcp_open <= !tcp_force_close;
      peer_response <= (keepalive_probe && mode == 2'h1) || wait_reg == 3'h1;
      if (keepalive_probe && mode == 2'h2) wait_reg <= 3'h4;
      else if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
    end
  end
endmodule

// ### verification/tb.sv
// Self-checking bench for the Ethernet link supervision block
`timescale 1ns/100ps
module tb import els_pkg::*;;
  localparam int SEC = 2;
  logic clk = 1'b0, rst_n = 1'b0, chk = 1'b0;
  logic [15:0] proto_select_slot1 = 16'h0, proto_select_slot2 = 16'h0;
  logic [15:0] proto_select_slot3 = 16'h0, proto_select_slot4 = 16'h0;
  logic [13:0] first_port_loss_action = 14'h0, second_port_loss_action = 14'h0, net_diag_select = 14'h0;
  logic [1:0] comm_error_stop_mode = 2'h0, peer_mode = 2'h1, fault_stop_mode;
  logic drive_running = 1'b0, cyclic_active = 1'b0, dup_ip_found = 1'b0;
  logic first_port_link_up = 1'b1, second_port_link_up = 1'b1;
  logic [12:0] keepalive_interval = 13'h0;
  logic [7:0] netmask_octet1_in = 8'h0, netmask_octet2_in = 8'h0;
  logic [7:0] netmask_octet3_in = 8'h0, netmask_octet4_in = 8'h0, slot_clients;
  logic tcp_open, peer_response, link_loss_warning, minor_alarm_output, link_loss_fault;
  logic keepalive_probe, tcp_force_close, snmp_enable, dup_check_req, duplicate_address_fault;
  logic [3:0] slot_valid, e_val;
  logic [31:0] netmask, e_mask, lf = 32'ha12c;
  logic [15:0] s[4];
  logic [1:0] e_cli[4], e_stop, plink;
  logic [2:0] e_loss;
  logic e_fault, e_probe, e_close, e_snmp, e_dreq, e_dupf, first, l1, l2, both, den, a_cyc, a_off;
  int cnt, prb, iv, n_fail = 0, comparisons = 0;
  logic [15:0] codes[16] = '{ELS_CODE_REGTCP, ELS_CODE_5000, ELS_CODE_5001, ELS_CODE_5002,
    ELS_CODE_5006, ELS_CODE_5007, ELS_CODE_5008, ELS_CODE_5010, ELS_CODE_5011, ELS_CODE_5012,
    ELS_CODE_5013, ELS_CODE_DIAGOFF, ELS_CODE_CYCLIC, ELS_CODE_UNSEL, ELS_CODE_44818, 16'hf00a};
  logic [13:0] acts2[8] = '{14'h0, 14'h1, 14'h2, 14'h3, 14'h22b8, 14'h270f, 14'h22b8, 14'h270f};
  logic [13:0] diags[4] = '{14'h0, 14'h1, 14'h2, 14'h270f};

  always #5 clk = ~clk;

  els_supervisor #(.SEC_CYCLES(SEC)) i_dut (.clk, .rst_n, .proto_select_slot1,
    .proto_select_slot2, .proto_select_slot3, .proto_select_slot4, .first_port_loss_action,
    .second_port_loss_action, .comm_error_stop_mode, .drive_running, .cyclic_active,
    .first_port_link_up, .second_port_link_up, .keepalive_interval, .tcp_open, .peer_response,
    .net_diag_select, .dup_ip_found, .netmask_octet1_in, .netmask_octet2_in, .netmask_octet3_in,
    .netmask_octet4_in, .slot_valid, .slot_clients, .link_loss_warning, .minor_alarm_output,
    .link_loss_fault, .fault_stop_mode, .keepalive_probe, .tcp_force_close, .snmp_enable,
    .dup_check_req, .duplicate_address_fault, .netmask);
  els_peer_model i_peer (.clk, .rst_n, .mode(peer_mode), .keepalive_probe, .tcp_force_close,
    .tcp_open, .peer_response);

  function automatic logic [31:0] nxt(logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction
  // Codes that share application and transport fall into one group
  function automatic int grp(logic [15:0] c);
    case (c)
      ELS_CODE_5000, ELS_CODE_5001, ELS_CODE_5006, ELS_CODE_5008: return 1;
      ELS_CODE_5002, ELS_CODE_5007: return 2;
      ELS_CODE_5010, ELS_CODE_5011: return 3;
      ELS_CODE_5012, ELS_CODE_5013: return 4;
      default: return 16 + c;
    endcase
  endfunction
  function automatic logic [1:0] cli(logic [15:0] c);
    if (c == ELS_CODE_REGTCP) return 2'h3;
    if (c == ELS_CODE_44818) return 2'h2;
    return (grp(c) == 2 || grp(c) == 4) ? 2'h2 : 2'h0;
  endfunction
  // Effect bits {protective, alarm, warning} of one action on a loss
  function automatic logic [2:0] eff(logic [13:0] a, logic lost);
    return lost ? {a == 14'h3, a == 14'h2 || a == 14'h3, a >= 14'h1 && a <= 14'h3} : 3'h0;
  endfunction

  // Reference model, stepped on the same edge the design samples
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {e_val, e_loss, e_fault, e_probe, e_close, e_snmp, e_dreq, e_dupf, plink} = '0;
      first = 1'b1;
      cnt = 0;
      prb = 0;
      e_mask = 32'hffffff00;
    end else begin
      s = '{proto_select_slot1, proto_select_slot2, proto_select_slot3, proto_select_slot4};
      a_cyc = 1'b0;
      a_off = 1'b0;
      for (int i = 0; i < 4; i++) begin
        e_val[i] = s[i] != ELS_CODE_UNSEL;
        for (int j = 0; j < i; j++) if (grp(s[j]) == grp(s[i])) e_val[i] = 1'b0;
        e_cli[i] = cli(s[i]);
        a_cyc |= s[i] == ELS_CODE_CYCLIC;
        a_off |= s[i] == ELS_CODE_DIAGOFF;
      end
      l1 = !first_port_link_up;
      l2 = !second_port_link_up;
      both = second_port_loss_action == 14'h22b8;
      if (both || second_port_loss_action == 14'h270f) e_loss = eff(first_port_loss_action, both ? l1 && l2 : l1 || l2);
      else e_loss = eff(first_port_loss_action, l1) | eff(second_port_loss_action, l2);
      e_fault = (e_loss[2] && drive_running) || (cyclic_active && a_cyc && (l1 || l2));
      e_stop = comm_error_stop_mode;
      e_snmp = (net_diag_select == 14'h1 || net_diag_select == 14'h270f) && !a_off;
      den = net_diag_select == 14'h2 || net_diag_select == 14'h270f;
      e_dreq = den && |({second_port_link_up, first_port_link_up} & ~plink);
      plink = {second_port_link_up, first_port_link_up};
      e_dupf = e_dupf || (den && dup_ip_found);
      iv = keepalive_interval == 13'h0 ? 1 : keepalive_interval > 13'd7200 ? 7200 : keepalive_interval;
      e_probe = 1'b0;
      e_close = 1'b0;
      cnt = (!tcp_open || peer_response) ? 0 : cnt + 1;
      if (!tcp_open || peer_response) prb = 0;
      if (cnt == iv * SEC) begin
        cnt = 0;
        e_close = prb == 7;
        e_probe = prb != 7;
        prb = (prb == 7) ? 0 : prb + 1;
      end
      if (first) e_mask = {netmask_octet1_in, netmask_octet2_in, netmask_octet3_in, netmask_octet4_in};
      first = 1'b0;
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Outputs are compared mid-cycle, once the edge's updates have landed
  always @(negedge clk) begin
    if (chk) begin
      for (int i = 0; i < 4; i++) begin
        check("slot_valid", slot_valid[i], e_val[i]);
        if (e_val[i]) check("slot_clients", slot_clients[2*i +: 2], e_cli[i]);
      end
      check("link_loss_warning", link_loss_warning, e_loss[0]);
      check("minor_alarm_output", minor_alarm_output, e_loss[1]);
      check("link_loss_fault", link_loss_fault, e_fault);
      if (e_fault) check("fault_stop_mode", fault_stop_mode, e_stop);
      check("keepalive_probe", keepalive_probe, e_probe);
      check("tcp_force_close", tcp_force_close, e_close);
      check("snmp_enable", snmp_enable, e_snmp);
      check("dup_check_req", dup_check_req, e_dreq);
      check("duplicate_address_fault", duplicate_address_fault, e_dupf);
      check("netmask", netmask, e_mask);
    end
  end

  // Random settings and link states each cycle; keepalive set only by the caller
  task automatic rnd(int n);
    repeat (n) begin
      @(posedge clk);
      lf = nxt(lf);
      proto_select_slot1 <= codes[lf[3:0]];
      proto_select_slot2 <= codes[lf[7:4]];
      proto_select_slot3 <= codes[lf[11:8]];
      proto_select_slot4 <= codes[lf[15:12]];
      {netmask_octet2_in, netmask_octet3_in} <= lf[31:16];
      lf = nxt(lf);
      first_port_loss_action <= {12'h0, lf[1:0]};
      second_port_loss_action <= acts2[lf[4:2]];
      comm_error_stop_mode <= lf[6:5];
      drive_running <= lf[7];
      cyclic_active <= lf[8];
      first_port_link_up <= |lf[10:9];
      second_port_link_up <= |lf[12:11];
      net_diag_select <= diags[lf[14:13]];
      dup_ip_found <= lf[19:15] == 5'h0;
      {netmask_octet1_in, netmask_octet4_in} <= lf[31:16];
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rnd(2);
    chk <= 1'b1;
    rnd(1500);
    keepalive_interval <= 13'h1;
    peer_mode <= 2'h0;
    rnd(80);
    keepalive_interval <= 13'h2;
    peer_mode <= 2'h2;
    rnd(80);
    peer_mode <= 2'h1;
    rnd(40);
    keepalive_interval <= 13'h1fff;
    peer_mode <= 2'h0;
    rnd(100);
    rst_n <= 1'b0;
    chk <= 1'b0;
    @(negedge clk);
    check("netmask", netmask, 32'hffffff00);
    check("reset outputs", {slot_valid, link_loss_fault, duplicate_address_fault}, 32'h0);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rnd(2);
    chk <= 1'b1;
    rnd(300);
    close_out();
  end
endmodule
